/* hw/pmi_power_mgmt.sv */
// Power management flags, enables, key-protected pin configuration and scratch registers
`timescale 1ns/1ps
// Operation
// - Registers are byte-wide processor special function registers at fixed addresses.
// - Bits 6:5 of pin config select calibration window and output frequency.
// - Pin config writes take effect only while key register holds unlock value.
// - Flag 7 sets when switched supply returns from battery to main supply.
// - Flag 6 sets when any enabled power-saving interrupt condition occurs.
// - Flag 5 sets on a line voltage sag reported by measurement engine.
// - Flag 3 sets on DC-input delta change or new DC-input measurement.
// - Flag 2 sets on battery below threshold or new battery measurement.
// - Flag 1 sets when switched supply moves from main supply to battery.
// - Each source has an enable at its flag position gating the summary flag.
module pmi_power_mgmt (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       bit_wr,
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wdata,
    input  wire logic       supply_source_main,
    input  wire logic       sag_event,
    input  wire logic       dc_input_delta_event,
    input  wire logic       dc_input_ready,
    input  wire logic       battery_low_event,
    input  wire logic       battery_ready,
    input  wire logic       dc_input_low_event,
    output logic            psm_summary_flag,
    output logic      [1:0] calib_freq_select,
    output logic      [2:0] ext_irq_b_function,
    output logic            ext_irq_a_function,
    output logic            ext_irq_a_enable,
    output logic            ext_irq_b_enable,
    output logic            battery_control_input,
    output logic      [7:0] battery_switch_config,
    output logic      [7:0] power_control
);
    logic [7:0] psm_interrupt_flags;
    logic [7:0] psm_interrupt_enable;
    logic [7:0] pin_function_config;
    logic [7:0] peripheral_config;
    logic [7:0] unlock_key_reg;
    logic [7:0] scratch_pad [4];
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic       supply_main_q;
    logic       unlocked;
    logic       next_summary;

    // Byte write strobe for one address
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
        wr_hit = sfr_wr && (a == target);
    endfunction : wr_hit

    // Open for as long as the key holds the value; a protected write does not consume it
    assign unlocked = (unlock_key_reg == pmi_pkg::UNLOCK_VALUE);

    // Supply source history for edge detection; starts on main supply
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_main_q <= 1'b1;
        end else begin
            supply_main_q <= supply_source_main;
        end
    end

    // Summary flag sets from an enabled source event, on the same clock edge as the source flag
    always_comb begin
        set_vec = 8'h00;
        set_vec[pmi_pkg::BIT_SUPPLY_RESTORED] = supply_source_main && !supply_main_q;
        set_vec[pmi_pkg::BIT_VOLTAGE_SAG]     = sag_event;
        set_vec[pmi_pkg::BIT_DC_INPUT_ADC]    = dc_input_delta_event || dc_input_ready;
        set_vec[pmi_pkg::BIT_BATTERY_MONITOR] = battery_low_event || battery_ready;
        set_vec[pmi_pkg::BIT_SWITCHOVER]      = !supply_source_main && supply_main_q;
        set_vec[pmi_pkg::BIT_DC_INPUT_LOW]    = dc_input_low_event;
        next_summary = |(set_vec & psm_interrupt_enable & pmi_pkg::ENABLE_MASK);
        set_vec[pmi_pkg::BIT_PSM_SUMMARY]     = next_summary;
    end

    // Clear by writing zero, byte-wide or single bit; reserved bit 4 is never stored
    always_comb begin
        clr_vec = 8'h00;
        if (wr_hit(sfr_addr, pmi_pkg::ADDR_PSM_FLAGS)) begin
            clr_vec = ~sfr_wdata & pmi_pkg::FLAG_MASK;
        end
        if (bit_wr && !bit_wdata && bit_addr[7:3] == pmi_pkg::ADDR_PSM_FLAGS[7:3]) begin
            clr_vec[bit_addr[2:0]] = pmi_pkg::FLAG_MASK[bit_addr[2:0]];
        end
    end

    // Reserved flag bit has no storage, so no write can ever leave it set
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (pmi_pkg::FLAG_MASK[gi]) begin : g_live
                pmi_flag_bit u_flag (
                    .clk       (clk),
                    .rst       (rst),
                    .set_event (set_vec[gi]),
                    .clear_req (clr_vec[gi]),
                    .flag      (psm_interrupt_flags[gi])
                );
            end else begin : g_rsvd
                assign psm_interrupt_flags[gi] = 1'b0;
            end
        end
    endgenerate

    // Reserved enable bits are dropped on write so they always read back zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psm_interrupt_enable <= pmi_pkg::RST_ENABLE;
        end else if (wr_hit(sfr_addr, pmi_pkg::ADDR_PSM_ENABLE)) begin
            psm_interrupt_enable <= sfr_wdata & pmi_pkg::ENABLE_MASK;
        end
    end

    // Plain register; any value other than the unlock value locks the pin config again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unlock_key_reg <= pmi_pkg::RST_KEY;
        end else if (wr_hit(sfr_addr, pmi_pkg::ADDR_UNLOCK_KEY)) begin
            unlock_key_reg <= sfr_wdata;
        end
    end

    // Protects calibration timing from runaway code; the write itself leaves the key alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_function_config <= pmi_pkg::RST_PIN_CONFIG;
        end else if (wr_hit(sfr_addr, pmi_pkg::ADDR_PIN_CONFIG) && unlocked) begin
            pin_function_config <= sfr_wdata & pmi_pkg::PIN_CONFIG_MASK;
        end
    end

    // Storage only; of the battery register just the switchover field is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peripheral_config     <= pmi_pkg::RST_PERIPHERAL;
            battery_switch_config <= pmi_pkg::RST_BATTERY;
            power_control         <= pmi_pkg::RST_POWER_CTRL;
        end else begin
            if (wr_hit(sfr_addr, pmi_pkg::ADDR_PERIPHERAL_CONFIG)) begin
                peripheral_config <= sfr_wdata;
            end
            if (wr_hit(sfr_addr, pmi_pkg::ADDR_BATTERY_SWITCH)) begin
                battery_switch_config <= sfr_wdata & pmi_pkg::BATTERY_MASK;
            end
            if (wr_hit(sfr_addr, pmi_pkg::ADDR_POWER_CONTROL)) begin
                power_control <= sfr_wdata;
            end
        end
    end

    // The range check keeps the two-bit index cast from aliasing other addresses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                scratch_pad[i] <= pmi_pkg::RST_SCRATCH;
            end
        end else if (sfr_wr && sfr_addr >= pmi_pkg::ADDR_SCRATCH_A && sfr_addr <= pmi_pkg::ADDR_SCRATCH_D) begin
            scratch_pad[2'(sfr_addr - pmi_pkg::ADDR_SCRATCH_A)] <= sfr_wdata;
        end
    end

    // Registered outputs: summary flag and the outputs decoded from the pin configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psm_summary_flag      <= 1'b0;
            calib_freq_select     <= pmi_pkg::PMI_CAL_1HZ;
            ext_irq_b_function    <= 3'h0;
            ext_irq_a_function    <= 1'b0;
            ext_irq_a_enable      <= 1'b0;
            ext_irq_b_enable      <= 1'b0;
            battery_control_input <= 1'b0;
        end else begin
            // Mirrors the next value of flag 6 so the output and the flag move together
            psm_summary_flag      <= set_vec[pmi_pkg::BIT_PSM_SUMMARY]
                                     || (psm_interrupt_flags[pmi_pkg::BIT_PSM_SUMMARY]
                                         && !clr_vec[pmi_pkg::BIT_PSM_SUMMARY]);
            calib_freq_select     <= pin_function_config[pmi_pkg::CALIB_LSB +: 2];
            ext_irq_b_function    <= pin_function_config[pmi_pkg::EXT_B_LSB +: 3];
            ext_irq_a_function    <= pin_function_config[pmi_pkg::EXT_A_BIT];
            ext_irq_a_enable      <= pin_function_config[pmi_pkg::EXT_A_BIT];
            ext_irq_b_enable      <= pin_function_config[pmi_pkg::EXT_B_LSB + 2]
                                     && pin_function_config[pmi_pkg::EXT_B_LSB + 1];
            battery_control_input <= pin_function_config[pmi_pkg::EXT_B_LSB +: 2] == 2'b01;
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                pmi_pkg::ADDR_PSM_FLAGS:         sfr_rdata <= psm_interrupt_flags;
                pmi_pkg::ADDR_PSM_ENABLE:        sfr_rdata <= psm_interrupt_enable;
                pmi_pkg::ADDR_PIN_CONFIG:        sfr_rdata <= pin_function_config;
                pmi_pkg::ADDR_UNLOCK_KEY:        sfr_rdata <= unlock_key_reg;
                pmi_pkg::ADDR_PERIPHERAL_CONFIG: sfr_rdata <= peripheral_config;
                pmi_pkg::ADDR_BATTERY_SWITCH:    sfr_rdata <= battery_switch_config;
                pmi_pkg::ADDR_POWER_CONTROL:     sfr_rdata <= power_control;
                pmi_pkg::ADDR_SCRATCH_A:         sfr_rdata <= scratch_pad[0];
                pmi_pkg::ADDR_SCRATCH_B:         sfr_rdata <= scratch_pad[1];
                pmi_pkg::ADDR_SCRATCH_C:         sfr_rdata <= scratch_pad[2];
                pmi_pkg::ADDR_SCRATCH_D:         sfr_rdata <= scratch_pad[3];
                default:                         sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule : pmi_power_mgmt

/* hw/pmi_pkg.sv */
// Package: register addresses, field positions and reset values of the power management block
package pmi_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL     = 8'hC5;
    localparam logic [7:0] ADDR_UNLOCK_KEY        = 8'hC1;
    localparam logic [7:0] ADDR_PSM_ENABLE        = 8'hEC;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hF4;
    localparam logic [7:0] ADDR_BATTERY_SWITCH    = 8'hF5;
    localparam logic [7:0] ADDR_PSM_FLAGS         = 8'hF8;
    localparam logic [7:0] ADDR_SCRATCH_A         = 8'hFB;
    localparam logic [7:0] ADDR_SCRATCH_B         = 8'hFC;
    localparam logic [7:0] ADDR_SCRATCH_C         = 8'hFD;
    localparam logic [7:0] ADDR_SCRATCH_D         = 8'hFE;
    localparam logic [7:0] ADDR_PIN_CONFIG        = 8'hFF;

    localparam logic [7:0] UNLOCK_VALUE           = 8'hEA;

    // Flag bit positions
    localparam int BIT_SUPPLY_RESTORED = 7;
    localparam int BIT_PSM_SUMMARY     = 6;
    localparam int BIT_VOLTAGE_SAG     = 5;
    localparam int BIT_DC_INPUT_ADC    = 3;
    localparam int BIT_BATTERY_MONITOR = 2;
    localparam int BIT_SWITCHOVER      = 1;
    localparam int BIT_DC_INPUT_LOW    = 0;

    // Writable masks: flag bit 4, enable bits 6 and 4, pin config bits 7 and 4 are reserved
    localparam logic [7:0] FLAG_MASK       = 8'hEF;
    localparam logic [7:0] ENABLE_MASK     = 8'hAF;
    localparam logic [7:0] PIN_CONFIG_MASK = 8'h6F;
    localparam logic [7:0] BATTERY_MASK    = 8'h03;

    // Reset values
    localparam logic [7:0] RST_FLAGS       = 8'h00;
    localparam logic [7:0] RST_ENABLE      = 8'h00;
    localparam logic [7:0] RST_PIN_CONFIG  = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL  = 8'h60;
    localparam logic [7:0] RST_BATTERY     = 8'h00;
    localparam logic [7:0] RST_POWER_CTRL  = 8'h00;
    localparam logic [7:0] RST_SCRATCH     = 8'h00;
    localparam logic [7:0] RST_KEY         = 8'h00;

    // Pin config field positions
    localparam int CALIB_LSB    = 5;
    localparam int EXT_B_LSB    = 1;
    localparam int EXT_A_BIT    = 0;

    typedef enum logic [1:0] {
        PMI_CAL_1HZ    = 2'b00,
        PMI_CAL_512HZ  = 2'b01,
        PMI_CAL_500HZ  = 2'b10,
        PMI_CAL_16KHZ  = 2'b11
    } pmi_calib_e;
endpackage : pmi_pkg

/* hw/pmi_flag_bit.sv */
// One sticky flag: hardware set wins over software clear
`timescale 1ns/1ps
module pmi_flag_bit (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic set_event,
    input  wire logic clear_req,
    output logic      flag
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_event) begin
            flag <= 1'b1;
        end else if (clear_req) begin
            flag <= 1'b0;
        end
    end
endmodule : pmi_flag_bit

/* bench/pmi_power_mgmt_checker.sv */
// Checker: key lock, pin decode, read timing and summary flag properties
`timescale 1ns/1ps
module pmi_power_mgmt_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       bit_wr,
    input wire logic       sag_event,
    input wire logic       psm_summary_flag,
    input wire logic [1:0] calib_freq_select,
    input wire logic [2:0] ext_irq_b_function,
    input wire logic       ext_irq_a_function,
    input wire logic       ext_irq_a_enable,
    input wire logic       ext_irq_b_enable,
    input wire logic       battery_control_input
);
    logic key_open;
    logic sag_en;
    wire  pin_wr = sfr_wr && sfr_addr == 8'hFF;
    // Shadow of the key, rebuilt from bus writes since it is not a port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) key_open <= 1'b0;
        else if (sfr_wr && sfr_addr == 8'hC1) key_open <= sfr_wdata == 8'hEA;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sag_en <= 1'b0;
        else if (sfr_wr && sfr_addr == 8'hEC) sag_en <= sfr_wdata[5];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_locked_write_kept: assert property (
        pin_wr && !key_open |=> ##1 $stable({calib_freq_select, ext_irq_b_function, ext_irq_a_function}))
        else $error("pin config changed while locked");
    a_open_write_taken: assert property (
        pin_wr && key_open |=> ##1 {calib_freq_select, ext_irq_b_function} == $past({sfr_wdata[6:5], sfr_wdata[3:1]}, 2))
        else $error("unlocked pin config write not applied");
    a_irq_b_decode: assert property (
        ext_irq_b_enable == (ext_irq_b_function[2:1] == 2'b11) && battery_control_input == (ext_irq_b_function[1:0] == 2'b01))
        else $error("second interrupt pin decode wrong");
    a_irq_a_decode: assert property (ext_irq_a_enable == ext_irq_a_function)
        else $error("first interrupt pin decode wrong");
    a_unmapped_read_zero: assert property (sfr_rd && sfr_addr == 8'h10 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_sag_sets_summary: assert property (sag_event && sag_en |=> psm_summary_flag)
        else $error("enabled sag did not set summary");
    a_summary_sticky: assert property (
        psm_summary_flag && !bit_wr && !(sfr_wr && sfr_addr == 8'hF8) |=> psm_summary_flag)
        else $error("summary flag dropped without a clear");
endmodule : pmi_power_mgmt_checker

bind pmi_power_mgmt pmi_power_mgmt_checker u_chk (.*);

/* bench/tb.sv */
// Testbench: bench model of registers, key lock and flags compared with the block
`timescale 1ns/1ps
module tb;
    logic       clk, rst, sfr_wr, sfr_rd, bit_wr, bit_wdata, supply_source_main, psm_summary_flag;
    logic       ext_irq_a_function, ext_irq_a_enable, ext_irq_b_enable, battery_control_input;
    logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, battery_switch_config, power_control, d;
    logic [7:0] m_flag, m_en, m_pin, m_key;
    logic [5:0] ev;
    logic [1:0] calib_freq_select;
    logic [2:0] ext_irq_b_function;
    int         err_count, check_count;
    int         pos[8] = '{5, 3, 3, 2, 2, 0, 1, 7};
    logic [7:0] ra[6]  = '{8'hC5, 8'hEC, 8'hF5, 8'hFB, 8'hFC, 8'hFE};
    logic [7:0] rm[6]  = '{8'hFF, 8'hAF, 8'h03, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] za[6]  = '{8'hC1, 8'hF4, 8'hF8, 8'hFD, 8'hFF, 8'h10};

    pmi_power_mgmt DUT (.*, .sag_event(ev[0]), .dc_input_delta_event(ev[1]), .dc_input_ready(ev[2]),
        .battery_low_event(ev[3]), .battery_ready(ev[4]), .dc_input_low_event(ev[5]));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // An idle edge follows each write so sfr_wr is never lowered and raised in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [5:0] evs = 6'h00);
        sfr_wr    = 1'b1;
        sfr_addr  = a;
        sfr_wdata = v;
        ev        = evs;
        if (a == 8'hC1) m_key = v;
        if (a == 8'hEC) m_en = v & 8'hAF;
        if (a == 8'hF8) m_flag = m_flag & v;
        if (a == 8'hFF && m_key == 8'hEA) m_pin = v & 8'h6F;
        @(negedge clk);
        sfr_wr = 1'b0;
        ev     = '0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_rd   = 1'b1;
        sfr_addr = a;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
        check($sformatf("reg %h", a), sfr_rdata, exp);
    endtask : rd

    task automatic pins();
        logic [7:0] e;
        repeat (2) @(negedge clk);
        e = 8'({m_pin[3:2] == 2'b11, m_pin[2:1] == 2'b01, m_pin[3:1]});
        check("calib", 8'(calib_freq_select), 8'(m_pin[6:5]));
        check("irq_b", 8'({ext_irq_b_enable, battery_control_input, ext_irq_b_function}), e);
        check("irq_a", 8'({ext_irq_a_enable, ext_irq_a_function}), {6'h00, m_pin[0], m_pin[0]});
        rd(8'hFF, m_pin);
    endtask : pins

    // Index 6 drops the supply to battery, 7 restores it; both keep summary in step
    task automatic fire(input int i);
        if (i < 6) ev = 6'(1 << i);
        else supply_source_main = (i == 7);
        m_flag[pos[i]] = 1'b1;
        if (m_en[pos[i]]) m_flag[6] = 1'b1;
        @(negedge clk);
        ev = '0;
        @(negedge clk);
    endtask : fire

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #200000;
        err_count++;
        summarize();
    end

    initial begin
        {rst, sfr_wr, sfr_rd, bit_wr, bit_wdata, supply_source_main} = 6'b100001;
        {sfr_addr, sfr_wdata, bit_addr, ev, m_flag, m_en, m_pin, m_key} = '0;
        err_count   = 0;
        check_count = 0;
        void'($urandom(82751));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], 8'h00);
            rd(za[i], za[i] == 8'hF4 ? 8'h60 : 8'h00);
        end
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(ra[i], d);
            rd(ra[i], d & rm[i]);
        end
        wr(8'hC5, 8'h5A);
        wr(8'hF5, 8'hFE);
        check("power", power_control, 8'h5A);
        check("battery", battery_switch_config, 8'h02);
        $display("test register access done");
        wr(8'hFF, 8'h6F);
        pins();
        wr(8'hC1, 8'hEA);
        // Successive protected writes, each followed by a pin check, must all land without a fresh key
        for (int i = 0; i < 8; i++) begin
            d      = 8'($urandom);
            d[3:1] = 3'(i);
            d[6:5] = 2'(i);
            wr(8'hFF, d);
            pins();
        end
        wr(8'hC1, 8'h00);
        wr(8'hFF, ~m_pin);
        pins();
        $display("test key lock done");
        for (int r = 0; r < 4; r++) begin
            wr(8'hEC, r[0] ? 8'hFF : 8'($urandom));
            for (int i = 0; i < 8; i++) fire(i);
            rd(8'hF8, m_flag);
            check("summary", 8'(psm_summary_flag), 8'(m_flag[6]));
            wr(8'hF8, 8'hEF);
            rd(8'hF8, m_flag);
            bit_addr = 8'hF8 + 8'(pos[r * 2]);
            bit_wr   = 1'b1;
            m_flag[pos[r * 2]] = 1'b0;
            @(negedge clk);
            bit_wr = 1'b0;
            rd(8'hF8, m_flag);
            wr(8'hF8, 8'h00, 6'h01); // Sag in the clearing cycle wins
            m_flag = m_en[5] ? 8'h60 : 8'h20;
            rd(8'hF8, m_flag);
            wr(8'hF8, 8'h00);
        end
        $display("test flags done");
        fire(0);
        bit_addr  = 8'hFD;
        bit_wdata = 1'b1;
        bit_wr    = 1'b1;
        @(negedge clk);
        bit_wr = 1'b0;
        rd(8'hF8, m_flag);
        wr(8'hC1, 8'hEA);
        wr(8'hFF, 8'h2B);
        pins();
        rst = 1'b1;
        {m_flag, m_en, m_pin, m_key} = '0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(8'hC1, 8'h00);
        rd(8'hF8, 8'h00);
        check("summary", 8'(psm_summary_flag), 8'(m_flag[6]));
        pins();
        wr(8'hFF, 8'h6F);
        pins();
        $display("test mid-run reset done");
        summarize();
    end
endmodule : tb
